// file: verilog/psfc_defines.vh
`ifndef PSFC_DEFINES_VH
`define PSFC_DEFINES_VH

// Internal SFR space
`define PSFC_SFR_BASE        8'h80
`define PSFC_FLASH_CTRL_ADDR 8'hb2
// External data space
`define PSFC_XSFR_BASE       16'hfc00
`define PSFC_BURN_PULSE_ADDR 16'hffd1
`define PSFC_BURN_ARM_ADDR   16'hffd2
`define PSFC_SEC_STATE_ADDR  16'hffd7

// Flash control fields
`define PSFC_FC_PWE_BIT      0
`define PSFC_FC_MEEN_BIT     1
`define PSFC_FC_PROT_BIT     6
// Security state fields
`define PSFC_SS_FPE_BIT      7
`define PSFC_SS_STRAP_BIT    5
`define PSFC_SS_LOCK1_BIT    1
`define PSFC_SS_LOCK0_BIT    0

// Burn sequence codes
`define PSFC_CODE_SETUP      8'h54
`define PSFC_CODE_SEL_MODE0  8'h81
`define PSFC_CODE_SEL_MODE1  8'h82
`define PSFC_CODE_BURN       8'ha6
`define PSFC_CODE_END        8'h00

`define PSFC_RESET_BYTE      8'h00

// Burn interval
`define PSFC_BURN_TIME_US    500
`define PSFC_CLK_MHZ         10
`define PSFC_BURN_CYCLES     (`PSFC_BURN_TIME_US * `PSFC_CLK_MHZ)

`endif

// file: verilog/psfc_sync2.v
`timescale 1ns/10ps
module psfc_sync2 (
    clk,
    resetn,
    asyncIn,
    syncOut
);
    input  wire clk;
    input  wire resetn;
    input  wire asyncIn;
    output reg  syncOut;

    reg stage1;

    always @(posedge clk) begin
        if (!resetn) begin
            stage1  <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule // psfc_sync2

// file: verilog/psfc_fuse_control.v
`timescale 1ns/10ps
`include "psfc_defines.vh"

// What this block does
// - Flash control bit 0 steers move-through-pointer writes into flash.
// - Program write enable clears itself after each flash byte written.
// - Writes to program write enable are ignored while interrupts are enabled.
// - Bit 1 is write-only mass erase enable, rewritten per erase.
// - Bit 6 code protect: reset clears, set only, blocks external reads.
// - Setup value 0x54 at 0xffd1 prepares fuse control; others reserved.
// - Burn value 0xa6 at 0xffd2 burns; any other value stops burning.
// - Security bit 7 write-only enables permanent fuse programming.
// - Security bit 5 reads the synchronised strap pin level.
// - Extended registers decode at the top of external data space.
// - Unimplemented addresses read as 0x00, writes have no effect.
// - Code protect activates mode 0 only with the mode 0 fuse blown.
// - Mode 0 restricts the debug port to bulk erase only.
// - Mode 1 fuse blown disables the debug port permanently.
module psfc_fuse_control #(
    parameter BURN_CYCLES = `PSFC_BURN_CYCLES
) (
    clk,
    resetn,
    sfrAddr,
    sfrWrite,
    sfrRead,
    sfrWdata,
    sfrRdata,
    xAddr,
    xWrite,
    xRead,
    xWdata,
    xRdata,
    intEnabled,
    flashByteDone,
    massEraseDone,
    strapPin,
    fuseMode0In,
    fuseMode1In,
    program_write_en,
    mass_erase_en,
    code_protect,
    extReadBlock,
    debugBulkOnly,
    debugDisabled,
    burnCurrentMode0,
    burnCurrentMode1,
    burnTimeUp
);
    input  wire        clk;
    input  wire        resetn;
    input  wire [7:0]  sfrAddr;
    input  wire        sfrWrite;
    input  wire        sfrRead;
    input  wire [7:0]  sfrWdata;
    output reg  [7:0]  sfrRdata;
    input  wire [15:0] xAddr;
    input  wire        xWrite;
    input  wire        xRead;
    input  wire [7:0]  xWdata;
    output reg  [7:0]  xRdata;
    input  wire        intEnabled;
    input  wire        flashByteDone;
    input  wire        massEraseDone;
    input  wire        strapPin;
    input  wire        fuseMode0In;
    input  wire        fuseMode1In;
    output reg         program_write_en;
    output reg         mass_erase_en;
    output reg         code_protect;
    output reg         extReadBlock;
    output reg         debugBulkOnly;
    output reg         debugDisabled;
    output reg         burnCurrentMode0;
    output reg         burnCurrentMode1;
    output reg         burnTimeUp;

    reg  [7:0]  burn_pulse_reg;
    reg  [7:0]  burn_arm_reg;
    reg         fuse_program_en;
    reg  [7:0]  burnSelect;
    reg  [15:0] burnCount;
    wire        strap_level;
    wire        lock_fuse_mode0;
    wire        lock_fuse_mode1;

    // Pins from outside the clock domain are synchronised first
    psfc_sync2 uStrap (
        .clk     (clk),
        .resetn  (resetn),
        .asyncIn (strapPin),
        .syncOut (strap_level)
    );
    psfc_sync2 uFuse0 (
        .clk     (clk),
        .resetn  (resetn),
        .asyncIn (fuseMode0In),
        .syncOut (lock_fuse_mode0)
    );
    psfc_sync2 uFuse1 (
        .clk     (clk),
        .resetn  (resetn),
        .asyncIn (fuseMode1In),
        .syncOut (lock_fuse_mode1)
    );

    // Extended space sits above 0xfc00; only three locations decode
    function xHit;
        input [15:0] addr;
        input [15:0] target;
        begin
            xHit = (addr >= `PSFC_XSFR_BASE) && (addr == target);
        end
    endfunction

    // Register roles of the codes are not trusted, so a code counts in either register
    function eitherHolds;
        input [7:0] regA;
        input [7:0] regB;
        input [7:0] code;
        begin
            eitherHolds = (regA == code) || (regB == code);
        end
    endfunction

    function isSelect;
        input [7:0] value;
        begin
            isSelect = (value == `PSFC_CODE_SEL_MODE0) || (value == `PSFC_CODE_SEL_MODE1);
        end
    endfunction

    wire fcWrite = sfrWrite && (sfrAddr == `PSFC_FLASH_CTRL_ADDR);
    wire pulseWr = xWrite && xHit(xAddr, `PSFC_BURN_PULSE_ADDR);
    wire armWr   = xWrite && xHit(xAddr, `PSFC_BURN_ARM_ADDR);
    wire secWr   = xWrite && xHit(xAddr, `PSFC_SEC_STATE_ADDR);
    wire secRd   = xRead && xHit(xAddr, `PSFC_SEC_STATE_ADDR);

    // Burn needs enable, setup code, burn code and a fuse chosen
    wire armed   = fuse_program_en && eitherHolds(burn_pulse_reg, burn_arm_reg, `PSFC_CODE_SETUP);
    wire burning = armed && eitherHolds(burn_pulse_reg, burn_arm_reg, `PSFC_CODE_BURN);
    wire next_burn0 = burning && (burnSelect == `PSFC_CODE_SEL_MODE0);
    wire next_burn1 = burning && (burnSelect == `PSFC_CODE_SEL_MODE1) && strap_level;

    always @(posedge clk) begin
        if (!resetn) begin
            program_write_en <= 1'b0;
            mass_erase_en    <= 1'b0;
            code_protect     <= 1'b0;
        end else begin
            // Byte completion wins over a simultaneous write
            if (flashByteDone)
                program_write_en <= 1'b0;
            else if (fcWrite && !intEnabled)
                program_write_en <= sfrWdata[`PSFC_FC_PWE_BIT];
            if (fcWrite)
                mass_erase_en <= sfrWdata[`PSFC_FC_MEEN_BIT];
            else if (massEraseDone)
                mass_erase_en <= 1'b0;
            if (fcWrite && sfrWdata[`PSFC_FC_PROT_BIT])
                code_protect <= 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            burn_pulse_reg  <= `PSFC_RESET_BYTE;
            burn_arm_reg    <= `PSFC_RESET_BYTE;
            fuse_program_en <= 1'b0;
            burnSelect      <= `PSFC_RESET_BYTE;
        end else begin
            if (pulseWr)
                burn_pulse_reg <= xWdata;
            if (armWr)
                burn_arm_reg <= xWdata;
            // Remember the last selection code whichever register got it
            if ((pulseWr || armWr) && isSelect(xWdata))
                burnSelect <= xWdata;
            else if ((pulseWr || armWr) && xWdata == `PSFC_CODE_END)
                burnSelect <= `PSFC_RESET_BYTE;
            if (secWr)
                fuse_program_en <= xWdata[`PSFC_SS_FPE_BIT];
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            burnCurrentMode0 <= 1'b0;
            burnCurrentMode1 <= 1'b0;
            burnCount        <= 16'h0000;
            burnTimeUp       <= 1'b0;
            extReadBlock     <= 1'b0;
            debugBulkOnly    <= 1'b0;
            debugDisabled    <= 1'b0;
            sfrRdata         <= 8'h00;
            xRdata           <= 8'h00;
        end else begin
            // Current drops one cycle after either register changes away
            burnCurrentMode0 <= next_burn0;
            burnCurrentMode1 <= next_burn1;
            if (!(next_burn0 || next_burn1))
                burnCount <= 16'h0000;
            else if (burnCount != BURN_CYCLES[15:0])
                burnCount <= burnCount + 16'h0001;
            burnTimeUp    <= (next_burn0 || next_burn1) && (burnCount == BURN_CYCLES[15:0]);
            extReadBlock  <= code_protect;
            debugBulkOnly <= code_protect && lock_fuse_mode0;
            // Sticky: once seen blown, only reset could clear, and the fuse stays blown
            debugDisabled <= debugDisabled || lock_fuse_mode1;
            if (sfrRead && sfrAddr == `PSFC_FLASH_CTRL_ADDR)
                sfrRdata <= {1'b0, code_protect, 5'b00000, program_write_en};
            else if (sfrRead)
                sfrRdata <= 8'h00;
            if (secRd)
                xRdata <= {2'b00, strap_level, 3'b000, lock_fuse_mode1, lock_fuse_mode0};
            else if (xRead)
                xRdata <= 8'h00;
        end
    end
endmodule // psfc_fuse_control

// file: bench/psfc_checker.sv
`timescale 1ns/10ps
module psfc_checker (
    input wire        clk,
    input wire        resetn,
    input wire        sfrWrite,
    input wire        xWrite,
    input wire        intEnabled,
    input wire        flashByteDone,
    input wire        massEraseDone,
    input wire [7:0]  sfrAddr,
    input wire [7:0]  sfrWdata,
    input wire [7:0]  xWdata,
    input wire [15:0] xAddr,
    input wire        program_write_en,
    input wire        mass_erase_en,
    input wire        code_protect,
    input wire        extReadBlock,
    input wire        debugDisabled,
    input wire        burnCurrentMode0,
    input wire        burnCurrentMode1
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire fcWr = sfrWrite && sfrAddr == 8'hb2;
    // Any code but setup or burn in either burn register breaks the burn condition
    sequence clearWrite;
        xWrite && xWdata != 8'ha6 && xWdata != 8'h54 && (xAddr == 16'hffd1 || xAddr == 16'hffd2);
    endsequence
    sequence burnOff;
        !burnCurrentMode0 && !burnCurrentMode1;
    endsequence
    pwe_auto_clear_a: assert property (flashByteDone |=> !program_write_en)
        else $error("write enable kept after flash byte");
    pwe_write_lock_a: assert property (fcWr && intEnabled && !flashByteDone |=> $stable(program_write_en))
        else $error("write enable changed with interrupts on");
    pwe_write_set_a: assert property (fcWr && !intEnabled && sfrWdata[0] && !flashByteDone |=> program_write_en)
        else $error("write enable not set");
    protect_sticky_a: assert property (code_protect |=> code_protect)
        else $error("code protect cleared without reset");
    protect_set_a: assert property (fcWr && sfrWdata[6] |=> code_protect)
        else $error("code protect not set");
    read_block_a: assert property ($rose(code_protect) |=> extReadBlock)
        else $error("external read not blocked");
    erase_done_a: assert property (massEraseDone && !fcWr |=> !mass_erase_en)
        else $error("mass erase enable kept after erase");
    erase_arm_a: assert property (fcWr && sfrWdata[1] |=> mass_erase_en)
        else $error("mass erase enable not set");
    debug_locked_a: assert property (debugDisabled |=> debugDisabled [*3])
        else $error("debug port came back");
    // Current is registered behind the burn registers, so it falls on the second edge
    burn_stop_a: assert property (clearWrite |=> ##1 burnOff)
        else $error("burn current kept after stop");
endmodule // psfc_checker

// file: bench/tb.sv
`timescale 1ns/10ps
module tb;
    reg         clk, resetn, sfrWrite, sfrRead, xWrite, xRead, intEnabled, flashByteDone, massEraseDone;
    reg         strapPin, fuseMode0In, fuseMode1In;
    reg  [7:0]  sfrAddr, sfrWdata, xWdata;
    reg  [15:0] xAddr;
    wire [7:0]  sfrRdata, xRdata;
    wire        program_write_en, mass_erase_en, code_protect, extReadBlock, debugBulkOnly, debugDisabled;
    wire        burnCurrentMode0, burnCurrentMode1, burnTimeUp;
    integer     errors = 0;
    integer     compares = 0;
    // Short burn count keeps the run brief
    psfc_fuse_control #(.BURN_CYCLES(20)) u_psfc_fuse_control (.clk, .resetn, .sfrAddr, .sfrWrite, .sfrRead,
        .sfrWdata, .sfrRdata, .xAddr, .xWrite, .xRead, .xWdata, .xRdata, .intEnabled, .flashByteDone,
        .massEraseDone, .strapPin, .fuseMode0In, .fuseMode1In, .program_write_en, .mass_erase_en, .code_protect,
        .extReadBlock, .debugBulkOnly, .debugDisabled, .burnCurrentMode0, .burnCurrentMode1, .burnTimeUp);
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    task tally_and_finish; begin
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end endtask
    task chk(input [7:0] got, input [7:0] exp); begin
        compares = compares + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end endtask
    task idle(input integer n); repeat (n) @(negedge clk); endtask
    task sw(input [7:0] a, input [7:0] d); begin
        @(negedge clk);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = 1;
        @(negedge clk);
        sfrWrite = 0;
    end endtask
    task sr(input [7:0] a, input [7:0] m, input [7:0] e); begin
        @(negedge clk);
        sfrAddr = a;
        sfrRead = 1;
        @(negedge clk);
        sfrRead = 0;
        chk(sfrRdata & m, e);
    end endtask
    task xw(input [15:0] a, input [7:0] d); begin
        @(negedge clk);
        xAddr = a;
        xWdata = d;
        xWrite = 1;
        @(negedge clk);
        xWrite = 0;
    end endtask
    task xr(input [15:0] a, input [7:0] m, input [7:0] e); begin
        @(negedge clk);
        xAddr = a;
        xRead = 1;
        @(negedge clk);
        xRead = 0;
        chk(xRdata & m, e);
    end endtask
    // Enable, setup, select, trigger in that order
    task burn(input [7:0] en, input [7:0] sel); begin
        xw(16'hffd7, en);
        xw(16'hffd1, 8'h54);
        xw(16'hffd2, sel);
        xw(16'hffd2, 8'ha6);
        idle(2);
    end endtask
    task stop; begin
        xw(16'hffd2, 8'h00);
        xw(16'hffd1, 8'h00);
        idle(1);
    end endtask
    initial begin
        #(2000 * 100);
        errors = errors + 1;
        tally_and_finish;
    end
    initial begin
        {sfrWrite, sfrRead, xWrite, xRead, intEnabled, flashByteDone, massEraseDone} = 0;
        {strapPin, fuseMode0In, fuseMode1In, sfrAddr, sfrWdata, xAddr, xWdata} = 0;
        resetn = 0;
        repeat (5) @(negedge clk);
        resetn = 1;
        chk({code_protect, program_write_en, mass_erase_en, debugDisabled}, 8'h00);
        sr(8'hb2, 8'hff, 8'h00);
        sr(8'hb3, 8'hff, 8'h00);
        intEnabled = 1;
        sw(8'hb2, 8'h01);
        chk(program_write_en, 8'h00);
        intEnabled = 0;
        sw(8'hb3, 8'h03);
        chk(mass_erase_en, 8'h00);
        sw(8'hb2, 8'h03);
        chk({program_write_en, mass_erase_en}, 8'h03);
        intEnabled = 1;
        sw(8'hb2, 8'h02);
        chk(program_write_en, 8'h01);
        intEnabled = 0;
        @(negedge clk);
        flashByteDone = 1;
        massEraseDone = 1;
        @(negedge clk);
        flashByteDone = 0;
        massEraseDone = 0;
        chk({program_write_en, mass_erase_en}, 8'h00);
        sw(8'hb2, 8'h40);
        sw(8'hb2, 8'h00);
        sr(8'hb2, 8'h40, 8'h40);
        chk(extReadBlock, 8'h01);
        chk(debugBulkOnly, 8'h00);
        strapPin = 1;
        idle(3);
        xr(16'hffd7, 8'h23, 8'h20);
        xr(16'h7fd7, 8'hff, 8'h00);
        burn(8'h80, 8'h81);
        chk({burnCurrentMode0, burnCurrentMode1}, 8'h02);
        // Current rose two edges ago; the time-up flag follows after 20 edges of burning
        idle(18);
        chk(burnTimeUp, 8'h00);
        idle(1);
        chk(burnTimeUp, 8'h01);
        xw(16'hffd2, 8'h55);
        idle(1);
        chk({burnCurrentMode0, burnCurrentMode1}, 8'h00);
        stop;
        burn(8'h00, 8'h81);
        chk({burnCurrentMode0, burnCurrentMode1}, 8'h00);
        stop;
        strapPin = 0;
        idle(3);
        burn(8'h80, 8'h82);
        chk({burnCurrentMode0, burnCurrentMode1}, 8'h00);
        stop;
        strapPin = 1;
        idle(3);
        burn(8'h80, 8'h82);
        chk({burnCurrentMode0, burnCurrentMode1}, 8'h01);
        stop;
        chk({burnCurrentMode0, burnCurrentMode1}, 8'h00);
        fuseMode0In = 1;
        fuseMode1In = 1;
        idle(4);
        chk({debugBulkOnly, debugDisabled}, 8'h03);
        fuseMode1In = 0;
        idle(4);
        chk(debugDisabled, 8'h01);
        tally_and_finish;
    end
endmodule // tb
bind psfc_fuse_control psfc_checker u_psfc_checker (.clk, .resetn, .sfrWrite, .xWrite, .intEnabled, .flashByteDone,
    .massEraseDone, .sfrAddr, .sfrWdata, .xWdata, .xAddr, .program_write_en, .mass_erase_en, .code_protect,
    .extReadBlock, .debugDisabled, .burnCurrentMode0, .burnCurrentMode1);
